/* logic/cosem_core.sv */
// Execution core for a subset of 8-bit ops, driven over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none

module cosem_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================================
  // Architectural state
  cosem_pkg::cosem_state_t state_reg, state_next;
  cosem_pkg::cosem_instr_t instr_reg, instr_next;
  cosem_pkg::cosem_status_t status_reg, status_next;
  logic [7:0] accum_reg, accum_next;
  logic [14:0] pc_reg, pc_next;
  logic [6:0] pclatch_reg, pclatch_next;
  logic [14:0] stack_head_reg, stack_head_next;
  logic [7:0] watchdog_counter_reg, watchdog_counter_next;
  logic [7:0] prescaler_reg, prescaler_next;
  logic skip_reg, skip_next;
  logic [6:0] file_idx_reg, file_idx_next;
  logic [7:0] file_mem [cosem_pkg::FILE_DEPTH];
  logic file_we;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata;

  // Bus state
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // ==========================================================================
  // Write decode
  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire wr_go = !awready_reg && !wready_reg && !bvalid_reg &&
               (state_reg == cosem_pkg::st_idle);
  wire hit_instr = aw_addr_reg == cosem_pkg::ADDR_INSTR;
  wire hit_accum = aw_addr_reg == cosem_pkg::ADDR_ACCUM;
  wire hit_status = aw_addr_reg == cosem_pkg::ADDR_STATUS;
  wire hit_pc = aw_addr_reg == cosem_pkg::ADDR_PC;
  wire hit_pclatch = aw_addr_reg == cosem_pkg::ADDR_PCLATCH;
  wire hit_idx = aw_addr_reg == cosem_pkg::ADDR_FILE_IDX;
  wire hit_fdata = aw_addr_reg == cosem_pkg::ADDR_FILE_DATA;
  wire hit_ro = (aw_addr_reg == cosem_pkg::ADDR_STACK) ||
                (aw_addr_reg == cosem_pkg::ADDR_WDOG) ||
                (aw_addr_reg == cosem_pkg::ADDR_CORE);
  wire wr_mapped = hit_instr || hit_accum || hit_status || hit_pc ||
                   hit_pclatch || hit_idx || hit_fdata || hit_ro;
  wire [1:0] wr_resp = wr_mapped ? cosem_pkg::RESP_OKAY : cosem_pkg::RESP_SLVERR;

  wire [31:0] acc_merge = cosem_pkg::cosem_merge({24'h00_0000, accum_reg}, w_data_reg,
                                                 w_strb_reg);
  wire [31:0] stat_merge = cosem_pkg::cosem_merge({29'h0000_0000, status_reg},
                                                  w_data_reg, w_strb_reg);
  wire [31:0] pc_merge = cosem_pkg::cosem_merge({17'h0_0000, pc_reg}, w_data_reg,
                                                w_strb_reg);
  wire [31:0] lat_merge = cosem_pkg::cosem_merge({25'h000_0000, pclatch_reg}, w_data_reg,
                                                 w_strb_reg);
  wire [31:0] idx_merge = cosem_pkg::cosem_merge({25'h000_0000, file_idx_reg}, w_data_reg,
                                                 w_strb_reg);
  wire [31:0] fdat_merge = cosem_pkg::cosem_merge({24'h00_0000, file_mem[file_idx_reg]},
                                                  w_data_reg, w_strb_reg);
  wire cosem_pkg::cosem_instr_t instr_dec = '{
    faddr: w_data_reg[cosem_pkg::INSTR_FADDR_LSB +: 7],
    dest: w_data_reg[cosem_pkg::INSTR_DEST_BIT],
    op: cosem_pkg::cosem_op_t'(w_data_reg[cosem_pkg::INSTR_OP_LSB +: 4])
  };

  // ==========================================================================
  // Execute decode
  wire in_exec = state_reg == cosem_pkg::st_exec;
  // Discarded op after a zero decrement-skip runs as a nop
  wire cosem_pkg::cosem_op_t exec_op = skip_reg ? cosem_pkg::no_op : instr_reg.op;
  wire [7:0] file_val = file_mem[instr_reg.faddr];
  wire [7:0] dec_val = file_val - cosem_pkg::ONE_BYTE;
  wire op_comp = exec_op == cosem_pkg::complement_file_op;
  wire op_dec = exec_op == cosem_pkg::file_decrement_op;
  wire op_dsz = exec_op == cosem_pkg::decrement_skip_null_op;
  wire [7:0] alu_res = op_comp ? ~file_val : dec_val;
  wire alu_route = in_exec && (op_comp || op_dec || op_dsz);
  wire alu_to_file = alu_route && (instr_reg.dest == cosem_pkg::DEST_FILE);
  wire alu_to_acc = alu_route && (instr_reg.dest == cosem_pkg::DEST_ACCUM);
  wire zero_file = in_exec && (exec_op == cosem_pkg::zero_file_op);
  wire wdog_kick = in_exec && (exec_op == cosem_pkg::watchdog_kick_op);
  wire [15:0] wdog_inc = {watchdog_counter_reg, prescaler_reg} + cosem_pkg::WDOG_STEP;
  wire wdog_wrap = {watchdog_counter_reg, prescaler_reg} == cosem_pkg::WDOG_LAST;
  wire bus_file_wr = wr_go && hit_fdata;

  assign file_we = alu_to_file || zero_file || bus_file_wr;
  assign file_waddr = in_exec ? instr_reg.faddr : file_idx_reg;
  assign file_wdata = zero_file ? cosem_pkg::ZERO_BYTE :
                      alu_to_file ? alu_res : fdat_merge[7:0];

  // ==========================================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    instr_next = instr_reg;
    status_next = status_reg;
    accum_next = accum_reg;
    pc_next = pc_reg;
    pclatch_next = pclatch_reg;
    stack_head_next = stack_head_reg;
    skip_next = skip_reg;
    file_idx_next = file_idx_reg;
    {watchdog_counter_next, prescaler_next} = wdog_inc;
    case (state_reg)
      cosem_pkg::st_idle: begin
        if (wr_go) begin
          if (hit_instr) begin
            instr_next = instr_dec;
            state_next = cosem_pkg::st_exec;
          end
          if (hit_accum) begin
            accum_next = acc_merge[7:0];
          end
          if (hit_status) begin
            status_next = stat_merge[2:0];
          end
          if (hit_pc) begin
            pc_next = pc_merge[14:0];
          end
          if (hit_pclatch) begin
            pclatch_next = lat_merge[6:0];
          end
          if (hit_idx) begin
            file_idx_next = idx_merge[6:0];
          end
        end
      end
      cosem_pkg::st_exec: begin
        state_next = cosem_pkg::st_idle;
        pc_next = pc_reg + cosem_pkg::PC_STEP;
        skip_next = 1'b0;
        case (exec_op)
          cosem_pkg::watchdog_kick_op: begin
            watchdog_counter_next = cosem_pkg::WDOG_KICK_VAL;
            prescaler_next = cosem_pkg::PRESC_KICK_VAL;
            status_next.watchdog_expired_flag = 1'b1;
            status_next.sleep_entered_flag = 1'b1;
          end
          cosem_pkg::indirect_call_op: begin
            stack_head_next = pc_reg + cosem_pkg::PC_STEP;
            pc_next = {pclatch_reg, accum_reg};
            state_next = cosem_pkg::st_call_tail;
          end
          cosem_pkg::complement_file_op, cosem_pkg::file_decrement_op: begin
            status_next.result_null = cosem_pkg::cosem_is_null(alu_res);
          end
          cosem_pkg::zero_file_op, cosem_pkg::zero_accumulator_op: begin
            status_next.result_null = 1'b1;
          end
          cosem_pkg::decrement_skip_null_op: begin
            skip_next = cosem_pkg::cosem_is_null(dec_val);
          end
          default: begin
          end
        endcase
        if (exec_op == cosem_pkg::zero_accumulator_op) begin
          accum_next = cosem_pkg::ZERO_BYTE;
        end
        if (alu_to_acc) begin
          accum_next = alu_res;
        end
      end
      cosem_pkg::st_call_tail: begin
        state_next = cosem_pkg::st_idle;
      end
      default: begin
        state_next = cosem_pkg::st_idle;
      end
    endcase
    // Timeout wins over a software write of the same flag
    if (wdog_wrap && !wdog_kick) begin
      status_next.watchdog_expired_flag = 1'b0;
    end
  end

  // ==========================================================================
  // Read mux
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      cosem_pkg::ADDR_INSTR: rd_mux = {20'h0_0000, instr_reg};
      cosem_pkg::ADDR_ACCUM: rd_mux = {24'h00_0000, accum_reg};
      cosem_pkg::ADDR_STATUS: rd_mux = {29'h0000_0000, status_reg};
      cosem_pkg::ADDR_PC: rd_mux = {17'h0_0000, pc_reg};
      cosem_pkg::ADDR_PCLATCH: rd_mux = {25'h000_0000, pclatch_reg};
      cosem_pkg::ADDR_STACK: rd_mux = {17'h0_0000, stack_head_reg};
      cosem_pkg::ADDR_WDOG: rd_mux = {16'h0000, prescaler_reg, watchdog_counter_reg};
      cosem_pkg::ADDR_FILE_IDX: rd_mux = {25'h000_0000, file_idx_reg};
      cosem_pkg::ADDR_FILE_DATA: rd_mux = {24'h00_0000, file_mem[file_idx_reg]};
      cosem_pkg::ADDR_CORE: rd_mux = {30'h0000_0000, skip_reg,
                                      state_reg != cosem_pkg::st_idle};
      default: rd_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= cosem_pkg::st_idle;
      instr_reg <= cosem_pkg::INSTR_RST;
      status_reg <= cosem_pkg::STATUS_RST;
      accum_reg <= cosem_pkg::ACCUM_RST;
      pc_reg <= cosem_pkg::PC_RST;
      pclatch_reg <= cosem_pkg::PCLATCH_RST;
      stack_head_reg <= cosem_pkg::STACK_RST;
      watchdog_counter_reg <= cosem_pkg::WDOG_KICK_VAL;
      prescaler_reg <= cosem_pkg::PRESC_KICK_VAL;
      skip_reg <= 1'b0;
      file_idx_reg <= cosem_pkg::FILE_IDX_RST;
    end else begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      status_reg <= status_next;
      accum_reg <= accum_next;
      pc_reg <= pc_next;
      pclatch_reg <= pclatch_next;
      stack_head_reg <= stack_head_next;
      watchdog_counter_reg <= watchdog_counter_next;
      prescaler_reg <= prescaler_next;
      skip_reg <= skip_next;
      file_idx_reg <= file_idx_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < cosem_pkg::FILE_DEPTH; i++) begin
        file_mem[i] <= cosem_pkg::FILE_RST;
      end
    end else if (file_we) begin
      file_mem[file_waddr] <= file_wdata;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= cosem_pkg::RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_resp;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= cosem_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? cosem_pkg::RESP_OKAY : cosem_pkg::RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule
`default_nettype wire

/* common/cosem_pkg.sv */
// Package: register map, field layout, encodings and types of the op execution core
`default_nettype none
package cosem_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_ACCUM = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam logic [7:0] ADDR_PCLATCH = 8'h10;
  localparam logic [7:0] ADDR_STACK = 8'h14;
  localparam logic [7:0] ADDR_WDOG = 8'h18;
  localparam logic [7:0] ADDR_FILE_IDX = 8'h1c;
  localparam logic [7:0] ADDR_FILE_DATA = 8'h20;
  localparam logic [7:0] ADDR_CORE = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int INSTR_OP_LSB = 0;
  localparam int INSTR_DEST_BIT = 8;
  localparam int INSTR_FADDR_LSB = 16;
  localparam int STATUS_NULL_BIT = 0;
  localparam int STATUS_EXPIRED_BIT = 1;
  localparam int STATUS_SLEEP_BIT = 2;
  localparam int CORE_BUSY_BIT = 0;
  localparam int CORE_SKIP_BIT = 1;
  localparam int FILE_DEPTH = 128;

  // ==========================================================================
  // Reset and load values
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [6:0] PCLATCH_RST = 7'h00;
  localparam logic [14:0] STACK_RST = 15'h0000;
  localparam logic [6:0] FILE_IDX_RST = 7'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [7:0] WDOG_KICK_VAL = 8'h00;
  localparam logic [7:0] PRESC_KICK_VAL = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [14:0] PC_STEP = 15'h0001;
  localparam logic [15:0] WDOG_STEP = 16'h0001;
  localparam logic [15:0] WDOG_LAST = 16'hffff;
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================================
  // Encodings
  typedef enum logic [3:0] {
    no_op = 4'b0000,
    watchdog_kick_op = 4'b0001,
    indirect_call_op = 4'b0010,
    complement_file_op = 4'b0011,
    zero_file_op = 4'b0100,
    file_decrement_op = 4'b0101,
    zero_accumulator_op = 4'b0110,
    decrement_skip_null_op = 4'b0111
  } cosem_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_exec = 2'b01,
    st_call_tail = 2'b10
  } cosem_state_t;

  typedef struct packed {
    logic [6:0] faddr;
    logic dest;
    cosem_op_t op;
  } cosem_instr_t;

  typedef struct packed {
    logic sleep_entered_flag;
    logic watchdog_expired_flag;
    logic result_null;
  } cosem_status_t;

  localparam cosem_status_t STATUS_RST = 3'h6;
  localparam cosem_instr_t INSTR_RST = 12'h000;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] cosem_merge(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic cosem_is_null(input logic [7:0] value);
    return value == ZERO_BYTE;
  endfunction

endpackage
`default_nettype wire

/* verif/cosem_monitor.sv */
// Bus protocol checks for the op execution core
`timescale 1ns/10ps
`default_nettype none
module cosem_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Handshake steps
  sequence s_aw_take; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w_take; s_axi_wvalid && s_axi_wready; endsequence
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_b_done; s_axi_bvalid && s_axi_bready; endsequence
  sequence s_r_done; s_axi_rvalid && s_axi_rready; endsequence
  // ==========================================================================
  // Properties
  a_aw_closes: assert property (s_aw_take |=> !s_axi_awready && !s_axi_bvalid)
    else $error("awready high after address taken");
  a_write_answer: assert property ((s_aw_take and s_w_take) |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_reopen: assert property (s_b_done |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
    else $error("write channels not reopened");
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_read_reopen: assert property (s_r_done |=> s_axi_arready && !s_axi_rvalid)
    else $error("read channel not reopened");
  a_unmapped_read: assert property ((s_ar_take ##0 (s_axi_araddr > cosem_pkg::ADDR_CORE))
    |=> s_axi_rresp == cosem_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  a_mapped_read: assert property ((s_ar_take ##0 (s_axi_araddr[1:0] == 2'h0 &&
    s_axi_araddr <= cosem_pkg::ADDR_CORE)) |=> s_axi_rresp == cosem_pkg::RESP_OKAY)
    else $error("mapped read refused");
endmodule
bind cosem_core cosem_monitor i_cosem_monitor (.clk(clk), .reset_n(reset_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* verif/test_core_op_semantics_subset.sv */
// Self-checking bench for the op execution core
`timescale 1ns/10ps
`default_nettype none
module test_core_op_semantics_subset;
  localparam logic [7:0] A_AC = cosem_pkg::ADDR_ACCUM;
  localparam logic [7:0] A_ST = cosem_pkg::ADDR_STATUS;
  localparam logic [7:0] A_PC = cosem_pkg::ADDR_PC;
  localparam logic [7:0] A_FD = cosem_pkg::ADDR_FILE_DATA;
  localparam logic [7:0] A_CO = cosem_pkg::ADDR_CORE;
  localparam logic [7:0] A_SK = cosem_pkg::ADDR_STACK;
  localparam logic [1:0] OK = cosem_pkg::RESP_OKAY;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] v;
  int err_count = 0;
  int n_compared = 0;

  always #2 clk = ~clk;

  cosem_core i_cosem_core (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================================
  // Bus tasks
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r_exp);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge clk);
      aw_left = aw_left && !awready;
      w_left = w_left && !wready;
      awvalid <= aw_left;
      wvalid <= w_left;
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
    chk(32'(bresp), 32'(r_exp));
  endtask

  task automatic rdv(input logic [7:0] a, input logic [1:0] r_exp, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    chk(32'(rresp), 32'(r_exp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] d;
    rdv(a, OK, d);
    chk(d, 32'(exp));
  endtask

  task automatic op(input logic [3:0] code, input logic dest);
    wr(cosem_pkg::ADDR_INSTR, {9'h000, 7'h7f, 7'h00, dest, 4'h0, code}, OK);
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(A_ST, 16'h0006);
    wr(cosem_pkg::ADDR_FILE_IDX, 32'h0000_007f, OK);
    // Zero accumulator
    wr(A_AC, 32'h0000_0055, OK);
    wr(A_ST, 32'h0000_0000, OK);
    op(cosem_pkg::zero_accumulator_op, 1'b0);
    rd(A_AC, 16'h0000);
    rd(A_ST, 16'h0001);
    // Complement to both destinations
    wr(A_FD, 32'h0000_003c, OK);
    op(cosem_pkg::complement_file_op, 1'b0);
    rd(A_AC, 16'h00c3);
    rd(A_ST, 16'h0000);
    rd(A_FD, 16'h003c);
    op(cosem_pkg::complement_file_op, 1'b1);
    rd(A_FD, 16'h00c3);
    wr(A_FD, 32'h0000_00ff, OK);
    op(cosem_pkg::complement_file_op, 1'b1);
    rd(A_FD, 16'h0000);
    rd(A_ST, 16'h0001);
    // Zero file
    wr(A_FD, 32'h0000_0081, OK);
    wr(A_ST, 32'h0000_0000, OK);
    op(cosem_pkg::zero_file_op, 1'b0);
    rd(A_FD, 16'h0000);
    rd(A_ST, 16'h0001);
    // Decrement, to zero and through wrap
    wr(A_FD, 32'h0000_0001, OK);
    op(cosem_pkg::file_decrement_op, 1'b0);
    rd(A_AC, 16'h0000);
    rd(A_FD, 16'h0001);
    wr(A_FD, 32'h0000_0000, OK);
    op(cosem_pkg::file_decrement_op, 1'b1);
    rd(A_FD, 16'h00ff);
    rd(A_ST, 16'h0000);
    // Decrement-skip, nonzero then zero, then the discarded op
    wr(A_ST, 32'h0000_0005, OK);
    wr(A_FD, 32'h0000_0002, OK);
    wr(A_PC, 32'h0000_0100, OK);
    op(cosem_pkg::decrement_skip_null_op, 1'b1);
    rd(A_FD, 16'h0001);
    rd(A_CO, 16'h0000);
    wr(A_AC, 32'h0000_0033, OK);
    op(cosem_pkg::decrement_skip_null_op, 1'b0);
    rd(A_AC, 16'h0000);
    rd(A_CO, 16'h0002);
    op(cosem_pkg::complement_file_op, 1'b0);
    rd(A_AC, 16'h0000);
    rd(A_PC, 16'h0103);
    rd(A_ST, 16'h0005);
    // Indirect call with an op right behind it
    wr(cosem_pkg::ADDR_PCLATCH, 32'h0000_005a, OK);
    wr(A_AC, 32'h0000_00c3, OK);
    op(cosem_pkg::indirect_call_op, 1'b0);
    op(cosem_pkg::no_op, 1'b0);
    rd(A_PC, 16'h5ac4);
    rd(A_SK, 16'h0104);
    rd(A_ST, 16'h0005);
    // Watchdog kick, after the counter has left zero
    repeat (300) @(posedge clk);
    rdv(cosem_pkg::ADDR_WDOG, OK, v);
    chk(32'(v[7:0] != 8'h00), 32'h0000_0001);
    wr(A_ST, 32'h0000_0001, OK);
    op(cosem_pkg::watchdog_kick_op, 1'b0);
    rd(A_ST, 16'h0007);
    rdv(cosem_pkg::ADDR_WDOG, OK, v);
    chk(32'(v[7:0]), 32'h0000_0000);
    chk(32'(v[15:12]), 32'h0000_0000);
    rd(cosem_pkg::ADDR_INSTR, 16'h0fe1);
    // Refused and read-only places
    wr(8'h40, 32'h0000_00ff, cosem_pkg::RESP_SLVERR);
    rdv(8'h40, cosem_pkg::RESP_SLVERR, v);
    wr(A_SK, 32'h0000_7fff, OK);
    rd(A_SK, 16'h0104);
    // Operand address comes from the op, not from the index
    wr(cosem_pkg::ADDR_FILE_IDX, 32'h0000_0005, OK);
    wr(A_FD, 32'h0000_0011, OK);
    op(cosem_pkg::zero_file_op, 1'b0);
    rd(A_FD, 16'h0011);
    wr(cosem_pkg::ADDR_FILE_IDX, 32'h0000_007f, OK);
    rd(A_FD, 16'h0000);
    // Unassigned code runs as a nop
    op(4'h9, 1'b1);
    rd(A_FD, 16'h0000);
    rd(A_ST, 16'h0007);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
